// [src/bre_pkg.sv]
// constants and types for the boundary-run test engine
// Operation
// - opcode taken from control register bits 2..0
// - x00 selects sample inputs, toggle outputs
// - x01 selects 36-bit pattern generation
// - x10 selects 36-bit signature compression
// - 011 runs 18-bit signature plus pattern
// - 111 runs 18-bit signature plus counter
// - runs only with run instruction in idle
// - control cells 47..36 never stepped
// - enable cells 47..44 gate pin drive
// - valid only with one common flow direction
// - bad direction acts as bypass, no test
// - toggle mode: input cells capture pins
// - toggle mode: output cells invert, drive
// - 36-bit pattern steps rising, drives falling
// - 36-bit pattern: all-zero seed stays zero
// - 36-bit signature mode folds input pins into signature
// - 36-bit signature mode holds output latches
// - combined pattern: 18-bit generator on outputs
// - combined count: 18-bit up-counter on outputs
// - combined modes: 18-bit signature on inputs
// - operation runs while idle state held
// - enable cell zero means output mode
package bre_pkg;
    // =========================================================
    // widths and cell positions
    localparam int OP_W = 3;
    localparam int CHAIN_W = 48;
    localparam int DATA_W = 36;
    localparam int HALF_W = 18;
    localparam int BYTE_W = 9;
    localparam int CELL_B1_AB = 47;
    localparam int CELL_B2_AB = 46;
    localparam int CELL_B1_BA = 45;
    localparam int CELL_B2_BA = 44;
    localparam int STEP_CNT_W = 32;
    // =========================================================
    // opcode encodings
    localparam logic [1:0] OP_LOW_TOGGLE = 2'h0;
    localparam logic [1:0] OP_LOW_PATTERN = 2'h1;
    localparam logic [1:0] OP_LOW_COMPRESS = 2'h2;
    localparam logic [2:0] OP_COMPRESS_PATTERN = 3'h3;
    localparam logic [2:0] OP_COMPRESS_COUNT = 3'h7;
    localparam logic [2:0] OPCODE_RESET = 3'h0;
    // =========================================================
    // feedback taps, bit i set means stage i feeds the xor
    localparam logic [35:0] TAPS36_AB = 36'h800000800;
    localparam logic [35:0] TAPS36_BA = 36'h800000800;
    localparam logic [17:0] TAPS18_AB = 18'h20040;
    localparam logic [17:0] TAPS18_BA = 18'h20040;
    // =========================================================
    // decoded operation, one-hot
    typedef enum logic [4:0] {
        BRE_SAMPLE_AND_TOGGLE = 5'h01,
        BRE_PATTERN_GENERATE = 5'h02,
        BRE_SIGNATURE_COMPRESS = 5'h04,
        BRE_COMPRESS_WITH_PATTERN = 5'h08,
        BRE_COMPRESS_WITH_COUNT = 5'h10
    } bre_mode_t;
endpackage

// [src/bre_engine.sv]
// boundary-run test engine: cells, shadows, pins and status
`timescale 1ns/1ps
`default_nettype none
module bre_engine #(
    parameter logic [35:0] TAPS36_AB = bre_pkg::TAPS36_AB,
    parameter logic [35:0] TAPS36_BA = bre_pkg::TAPS36_BA,
    parameter logic [17:0] TAPS18_AB = bre_pkg::TAPS18_AB,
    parameter logic [17:0] TAPS18_BA = bre_pkg::TAPS18_BA
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic tck,
    input wire logic tap_reset,
    input wire logic boundary_run_instr,
    input wire logic tap_run_idle,
    input wire logic opcode_register_scan,
    input wire logic [2:0] opcode_din,
    input wire logic seed_load,
    input wire logic [47:0] seed_data,
    input wire logic update_dr,
    input wire logic [17:0] a_pin_in,
    input wire logic [17:0] b_pin_in,
    output logic [17:0] a_pin_out,
    output logic [17:0] a_pin_oe,
    output logic [17:0] b_pin_out,
    output logic [17:0] b_pin_oe,
    output logic [2:0] boundary_test_opcode,
    output logic [47:0] cell_shift,
    output logic [47:0] cell_shadow,
    output logic status_running,
    output logic status_bypassed,
    output logic [31:0] run_step_count
);
    // =========================================================
    // reset carried into the test-clock domain
    logic rst_tck_s1;
    logic rst_tck;

    always_ff @(posedge tck) begin
        rst_tck_s1 <= rst;
        rst_tck <= rst_tck_s1;
    end

    // =========================================================
    // opcode register, loaded by its own scan update
    always_ff @(posedge tck) begin
        if (rst_tck || tap_reset) begin
            boundary_test_opcode <= bre_pkg::OPCODE_RESET;
        end else if (opcode_register_scan) begin
            boundary_test_opcode <= opcode_din;
        end
    end

    bre_pkg::bre_mode_t mode;

    always_comb begin
        case (boundary_test_opcode[1:0])
            bre_pkg::OP_LOW_TOGGLE: begin
                mode = bre_pkg::BRE_SAMPLE_AND_TOGGLE;
            end
            bre_pkg::OP_LOW_PATTERN: begin
                mode = bre_pkg::BRE_PATTERN_GENERATE;
            end
            bre_pkg::OP_LOW_COMPRESS: begin
                mode = bre_pkg::BRE_SIGNATURE_COMPRESS;
            end
            default: begin
                if (boundary_test_opcode == bre_pkg::OP_COMPRESS_COUNT) begin
                    mode = bre_pkg::BRE_COMPRESS_WITH_COUNT;
                end else begin
                    mode = bre_pkg::BRE_COMPRESS_WITH_PATTERN;
                end
            end
        endcase
    end

    // =========================================================
    // direction check from the enable shadows
    logic b1_ab_n;
    logic b2_ab_n;
    logic b1_ba_n;
    logic b2_ba_n;
    logic dir_valid;
    logic dir_ab;
    logic test_drive;
    logic run;

    assign b1_ab_n = cell_shadow[bre_pkg::CELL_B1_AB];
    assign b2_ab_n = cell_shadow[bre_pkg::CELL_B2_AB];
    assign b1_ba_n = cell_shadow[bre_pkg::CELL_B1_BA];
    assign b2_ba_n = cell_shadow[bre_pkg::CELL_B2_BA];
    // each byte one way, both bytes the same way
    assign dir_valid = (b1_ab_n != b1_ba_n) && (b2_ab_n != b2_ba_n)
        && (b1_ab_n == b2_ab_n);
    // active-low enable toward b means a is the input side
    assign dir_ab = ~b1_ab_n;
    // outside a valid direction nothing is tested or driven
    assign test_drive = boundary_run_instr && dir_valid;
    assign run = test_drive && tap_run_idle;

    // =========================================================
    // output-mode mask per data cell, a pins low, b pins high
    logic [35:0] out_mask;

    genvar g;
    generate
        for (g = 0; g < bre_pkg::DATA_W; g = g + 1) begin : g_mask
            if (g < bre_pkg::BYTE_W) begin : g_a1
                assign out_mask[g] = ~b1_ba_n;
            end else if (g < bre_pkg::HALF_W) begin : g_a2
                assign out_mask[g] = ~b2_ba_n;
            end else if (g < bre_pkg::HALF_W + bre_pkg::BYTE_W) begin : g_b1
                assign out_mask[g] = ~b1_ab_n;
            end else begin : g_b2
                assign out_mask[g] = ~b2_ab_n;
            end
        end
    endgenerate

    // =========================================================
    // pin sampling, two stages before any use
    logic [35:0] pin_s1;
    logic [35:0] pin_s2;

    always_ff @(posedge tck) begin
        pin_s1 <= {b_pin_in, a_pin_in};
        pin_s2 <= pin_s1;
    end

    // =========================================================
    // step functions
    function automatic logic [35:0] step36(
        input logic [35:0] s,
        input logic [35:0] taps
    );
        step36 = {s[34:0], ^(s & taps)};
    endfunction

    function automatic logic [17:0] step18(
        input logic [17:0] s,
        input logic [17:0] taps
    );
        step18 = {s[16:0], ^(s & taps)};
    endfunction

    // =========================================================
    // next value of the data cells' shift stages
    logic [35:0] data_q;
    logic [35:0] in_bits;
    logic [35:0] taps36;
    logic [17:0] taps18;
    logic [17:0] in_half;
    logic [17:0] out_half;
    logic [17:0] in_pins;
    logic [17:0] next_in_half;
    logic [17:0] next_out_half;
    logic [35:0] next_data;

    assign data_q = cell_shift[bre_pkg::DATA_W-1:0];
    // only input-mode pins contribute to a signature
    assign in_bits = pin_s2 & ~out_mask;
    assign taps36 = dir_ab ? TAPS36_AB : TAPS36_BA;
    assign taps18 = dir_ab ? TAPS18_AB : TAPS18_BA;
    assign in_half = dir_ab ? data_q[17:0] : data_q[35:18];
    assign out_half = dir_ab ? data_q[35:18] : data_q[17:0];
    assign in_pins = dir_ab ? in_bits[17:0] : in_bits[35:18];

    always_comb begin
        next_in_half = step18(in_half, taps18) ^ in_pins;
        next_out_half = out_half;
        next_data = data_q;
        case (mode)
            bre_pkg::BRE_SAMPLE_AND_TOGGLE: begin
                // inputs capture, outputs invert
                next_data = (pin_s2 & ~out_mask)
                    | (~data_q & out_mask);
            end
            bre_pkg::BRE_PATTERN_GENERATE: begin
                next_data = step36(data_q, taps36);
            end
            bre_pkg::BRE_SIGNATURE_COMPRESS: begin
                next_data = step36(data_q, taps36) ^ in_bits;
            end
            bre_pkg::BRE_COMPRESS_WITH_PATTERN: begin
                next_out_half = step18(out_half, taps18);
                next_data = dir_ab ? {next_out_half, next_in_half}
                    : {next_in_half, next_out_half};
            end
            bre_pkg::BRE_COMPRESS_WITH_COUNT: begin
                next_out_half = out_half + 18'h00001;
                next_data = dir_ab ? {next_out_half, next_in_half}
                    : {next_in_half, next_out_half};
            end
            default: begin
                next_data = data_q;
            end
        endcase
    end

    // =========================================================
    // shift stages, stepped on rising test-clock edges
    always_ff @(posedge tck) begin
        if (rst_tck) begin
            cell_shift <= 48'h000000000000;
        end else if (seed_load) begin
            cell_shift <= seed_data;
        end else if (run) begin
            // control cells keep their scanned value
            cell_shift[bre_pkg::DATA_W-1:0] <= next_data;
        end
    end

    // =========================================================
    // shadow latches, updated on falling edges
    logic psa36;

    assign psa36 = (mode == bre_pkg::BRE_SIGNATURE_COMPRESS);

    always_ff @(negedge tck) begin
        if (rst_tck) begin
            cell_shadow <= 48'h000000000000;
        end else if (update_dr) begin
            cell_shadow <= cell_shift;
        end else if (run && !psa36) begin
            // output-mode cells pass their new value on
            cell_shadow[bre_pkg::DATA_W-1:0] <=
                (cell_shift[bre_pkg::DATA_W-1:0] & out_mask)
                | (cell_shadow[bre_pkg::DATA_W-1:0] & ~out_mask);
        end
        // 36-bit signature mode leaves every shadow as it is while running
    end

    // =========================================================
    // pin drive, registered on falling edges
    always_ff @(negedge tck) begin
        if (rst_tck) begin
            a_pin_out <= 18'h00000;
            b_pin_out <= 18'h00000;
            a_pin_oe <= 18'h00000;
            b_pin_oe <= 18'h00000;
        end else begin
            a_pin_out <= cell_shadow[17:0];
            b_pin_out <= cell_shadow[35:18];
            if (test_drive) begin
                a_pin_oe <= out_mask[17:0];
                b_pin_oe <= out_mask[35:18];
            end else begin
                // bypass leaves the pins to normal logic
                a_pin_oe <= 18'h00000;
                b_pin_oe <= 18'h00000;
            end
        end
    end

    // =========================================================
    // status levels and step events toward the system clock
    logic run_lvl;
    logic bypass_lvl;
    logic step_tgl;

    always_ff @(posedge tck) begin
        if (rst_tck) begin
            run_lvl <= 1'b0;
            bypass_lvl <= 1'b0;
            step_tgl <= 1'b0;
        end else begin
            run_lvl <= run;
            bypass_lvl <= boundary_run_instr && !dir_valid;
            if (run) begin
                step_tgl <= ~step_tgl;
            end
        end
    end

    logic run_s1;
    logic bypass_s1;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;

    // test clock is about a quarter of clk, so a toggle is never missed
    always_ff @(posedge clk) begin
        if (rst) begin
            run_s1 <= 1'b0;
            bypass_s1 <= 1'b0;
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
        end else if (ce) begin
            run_s1 <= run_lvl;
            bypass_s1 <= bypass_lvl;
            tgl_s1 <= step_tgl;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_running <= 1'b0;
            status_bypassed <= 1'b0;
        end else if (ce) begin
            status_running <= run_s1;
            status_bypassed <= bypass_s1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            run_step_count <= 32'h00000000;
        end else if (ce && (tgl_s2 != tgl_s3)) begin
            run_step_count <= run_step_count + 32'h00000001;
        end
    end
endmodule
`default_nettype wire

// [tb/bre_chk.sv]
// port-level assertions for the boundary-run test engine
`timescale 1ns/1ps
`default_nettype none
module bre_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic boundary_run_instr,
    input wire logic tap_run_idle,
    input wire logic opcode_register_scan,
    input wire logic [2:0] opcode_din,
    input wire logic seed_load,
    input wire logic update_dr,
    input wire logic [17:0] a_pin_out,
    input wire logic [17:0] a_pin_oe,
    input wire logic [17:0] b_pin_out,
    input wire logic [17:0] b_pin_oe,
    input wire logic [2:0] boundary_test_opcode,
    input wire logic [47:0] cell_shift,
    input wire logic [47:0] cell_shadow,
    input wire logic [31:0] run_step_count
);
    // ==========
    // direction taken from the enable shadows
    wire [47:0] sh = cell_shadow;
    wire run = boundary_run_instr && tap_run_idle && !seed_load;
    wire ab = sh[47:44] == 4'h3;
    wire dir_ok = sh[47] != sh[45] && sh[46] != sh[44] && sh[47] == sh[46];
    wire [1:0] op_lo = boundary_test_opcode[1:0];
    opcode_load_a: assert property (@(posedge tck) disable iff (rst)
        opcode_register_scan |=> boundary_test_opcode == $past(opcode_din))
        else $error("opcode register missed a load");
    idle_hold_a: assert property (@(posedge tck) disable iff (rst)
        !(boundary_run_instr && tap_run_idle) && !seed_load
        |=> $stable(cell_shift)) else $error("cells moved outside idle");
    bypass_hold_a: assert property (@(posedge tck) disable iff (rst)
        !dir_ok && !seed_load |=> $stable(cell_shift))
        else $error("cells moved with mixed direction");
    ctrl_cells_a: assert property (@(posedge tck) disable iff (rst)
        !seed_load |=> $stable(cell_shift[47:36]))
        else $error("control cells stepped");
    toggle_out_a: assert property (@(posedge tck) disable iff (rst)
        run && ab && op_lo == 2'h0
        |=> cell_shift[35:18] == ~$past(cell_shift[35:18]))
        else $error("output cells did not invert");
    count_up_a: assert property (@(posedge tck) disable iff (rst)
        run && ab && boundary_test_opcode == 3'h7
        |=> cell_shift[35:18] == $past(cell_shift[35:18]) + 18'h1)
        else $error("counter did not advance by one");
    zero_seed_a: assert property (@(posedge tck) disable iff (rst)
        run && dir_ok && op_lo == 2'h1 && cell_shift[35:0] == 36'h0
        |=> cell_shift[35:0] == 36'h0) else $error("zero seed moved");
    sig_hold_a: assert property (@(negedge tck) disable iff (rst)
        op_lo == 2'h2 && !update_dr |=> $stable(cell_shadow))
        else $error("shadow changed in signature mode");
    pin_lag_a: assert property (@(negedge tck) disable iff (rst)
        1'b1 |=> {b_pin_out, a_pin_out} == $past(cell_shadow[35:0]))
        else $error("pins do not follow shadow");
    oe_drive_a: assert property (@(negedge tck) disable iff (rst)
        boundary_run_instr && ab && !update_dr
        |=> {b_pin_oe, a_pin_oe} == {18'h3ffff, 18'h0})
        else $error("wrong pin drive for a to b");
    step_count_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |-> run_step_count - $past(run_step_count) <= 32'h1)
        else $error("step count jumped");
endmodule
bind bre_engine bre_chk bre_chk_inst (.clk, .rst, .tck, .boundary_run_instr,
    .tap_run_idle, .opcode_register_scan, .opcode_din, .seed_load,
    .update_dr, .a_pin_out, .a_pin_oe, .b_pin_out, .b_pin_oe,
    .boundary_test_opcode, .cell_shift, .cell_shadow, .run_step_count);
`default_nettype wire

// [tb/bre_tap_model.sv]
// test controller model driving the engine's tap-side inputs
`timescale 1ns/1ps
`default_nettype none
module bre_tap_model (
    output logic tck,
    output logic run_instr,
    output logic run_idle,
    output logic op_scan,
    output logic [2:0] op_din,
    output logic seed_load,
    output logic [47:0] seed_data,
    output logic update_dr
);
    // ==========
    // tck runs free: the engine's reset crossing needs its edges
    initial begin
        {run_instr, run_idle, op_scan, seed_load, update_dr} = 5'h0;
        op_din = 3'h5;
        seed_data = 48'h0;
        tck = 1'b0;
        #5;
        forever #16 tck = ~tck;
    end
    // opcode first, then seed and shadow update; released data inverted
    task automatic load(input logic [2:0] op, input logic [47:0] sd);
        @(negedge tck);
        op_scan <= 1'b1;
        op_din <= op;
        @(negedge tck);
        op_scan <= 1'b0;
        op_din <= ~op;
        seed_load <= 1'b1;
        seed_data <= sd;
        @(posedge tck);
        seed_load <= 1'b0;
        seed_data <= ~sd;
        update_dr <= 1'b1;
        @(negedge tck);
        update_dr <= 1'b0;
    endtask
    task automatic run(input int n, input logic idle);
        @(negedge tck);
        run_instr <= 1'b1;
        run_idle <= idle;
        repeat (n) @(posedge tck);
        @(negedge tck);
        run_instr <= 1'b0;
        run_idle <= 1'b0;
        repeat (3) @(negedge tck);
    endtask
endmodule
`default_nettype wire

// [tb/boundary_run_test_engine_test.sv]
// self-checking bench for the boundary-run test engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
end
module boundary_run_test_engine_test;
    localparam int STEPS = 12;
    logic clk, rst, ce, tap_reset, tck, run_instr, run_idle, op_scan;
    logic seed_load, update_dr, running, bypassed;
    logic [2:0] op_din, opcode;
    logic [47:0] seed_data, shift, shadow;
    logic [17:0] a_in, b_in, a_out, b_out, a_oe, b_oe, a_ext, b_ext;
    logic [31:0] steps;
    logic [1:0] mid_st;
    logic [35:0] mid_oe;
    int err_total = 0;
    int n_compared = 0;
    // ==========
    // pins resolved from device drive and the far side's level
    assign a_in = (a_oe & a_out) | (~a_oe & a_ext);
    assign b_in = (b_oe & b_out) | (~b_oe & b_ext);
    bre_tap_model bre_tap_model_inst (.tck(tck), .run_instr(run_instr),
        .run_idle(run_idle), .op_scan(op_scan), .op_din(op_din),
        .seed_load(seed_load), .seed_data(seed_data), .update_dr(update_dr));
    bre_engine bre_engine_inst (.clk(clk), .rst(rst), .ce(ce), .tck(tck),
        .tap_reset(tap_reset), .boundary_run_instr(run_instr),
        .tap_run_idle(run_idle), .opcode_register_scan(op_scan),
        .opcode_din(op_din), .seed_load(seed_load), .seed_data(seed_data),
        .update_dr(update_dr), .a_pin_in(a_in), .b_pin_in(b_in),
        .a_pin_out(a_out), .a_pin_oe(a_oe), .b_pin_out(b_out),
        .b_pin_oe(b_oe), .boundary_test_opcode(opcode), .cell_shift(shift),
        .cell_shadow(shadow), .status_running(running),
        .status_bypassed(bypassed), .run_step_count(steps));
    function automatic logic [35:0] model(input logic [2:0] op,
        input logic d, input logic [35:0] s);
        logic [35:0] im, p, t;
        logic [17:0] t18, i, o;
        im = d ? 36'hf_fffc_0000 : 36'h0_0003_ffff;
        p = {b_ext, a_ext} & im;
        t = d ? bre_pkg::TAPS36_BA : bre_pkg::TAPS36_AB;
        t18 = d ? bre_pkg::TAPS18_BA : bre_pkg::TAPS18_AB;
        repeat (STEPS) begin
            i = d ? s[35:18] : s[17:0];
            o = d ? s[17:0] : s[35:18];
            case (op[1:0])
                2'h0: s = p | (~s & ~im);
                2'h1: s = {s[34:0], ^(s & t)};
                2'h2: s = {s[34:0], ^(s & t)} ^ p;
                default: begin
                    i = {i[16:0], ^(i & t18)} ^ (d ? b_ext : a_ext);
                    o = op[2] ? o + 18'h1 : {o[16:0], ^(o & t18)};
                    s = d ? {i, o} : {o, i};
                end
            endcase
        end
        return s;
    endfunction
    task automatic trial(input logic [2:0] op, input logic [47:0] sd,
        input logic idle, input logic [1:0] st);
        logic [35:0] om, e, sh;
        logic [31:0] c0;
        om = sd[47:44] == 4'hc ? 36'h3ffff : 36'hf_fffc_0000;
        e = st[1] ? model(op, sd[47:44] == 4'hc, sd[35:0]) : sd[35:0];
        sh = op[1:0] == 2'h2 ? sd[35:0] : e;
        bre_tap_model_inst.load(op, sd);
        c0 = steps;
        fork
            bre_tap_model_inst.run(STEPS, idle);
            begin
                repeat (30) @(negedge clk);
                mid_st = {running, bypassed};
                mid_oe = {b_oe, a_oe};
            end
        join
        repeat (8) @(negedge clk);
        `CHK("opcode", op, opcode)
        `CHK("cells", {sd[47:36], e}, shift)
        `CHK("pins", (sh & om) | (sd[35:0] & ~om), {b_out, a_out})
        `CHK("shd", {sd[47:36], (sh & om) | (sd[35:0] & ~om)}, shadow)
        `CHK("oe", st[0] ? 36'h0 : om, mid_oe)
        `CHK("status", st, mid_st)
        `CHK("steps", c0 + (st[1] ? STEPS : 0), steps)
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #60000;
        err_total++;
        conclude();
    end
    initial begin
        {rst, ce, tap_reset} = 3'h6;
        a_ext = 18'h2d5a3;
        b_ext = 18'h1c3e7;
        repeat (16) @(negedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge tck);
        `CHK("opcode reset", bre_pkg::OPCODE_RESET, opcode)
        // every opcode in both flow directions
        for (int k = 0; k < 16; k++)
            trial(k[2:0], {k[3] ? 4'hc : 4'h3, 8'h5a, 36'h9_c3a5_61e7},
                1'b1, 2'b10);
        trial(3'h1, {4'h3, 8'h5a, 36'h0}, 1'b1, 2'b10);
        trial(3'h3, {4'h3, 8'h5a, 36'h0}, 1'b1, 2'b10);
        trial(3'h1, {4'h3, 8'h5a, 36'h9_c3a5_61e7}, 1'b0, 2'b00);
        trial(3'h1, {4'h0, 8'h5a, 36'h9_c3a5_61e7}, 1'b1, 2'b01);
        conclude();
    end
endmodule
`default_nettype wire
